// *** rsr_ctrl.sv ***
// Reset and stop-recovery sequencer with APB status and control registers
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
// What this block does
// R01 - Watchdog timeout resets or interrupts per select
// R02 - Watchdog reset sets watchdog cause flag
// R03 - Reset pin low three to four cycles
// R04 - Stay in reset while pin held low
// R05 - Pin reset sets external cause flag
// R06 - Drive reset pin low through reset delay
// R07 - Debug request resets chip, not debug unit
// R08 - Debug request self-clears; power-up flag set
// R09 - Recovery holds 866 or 5000 cycles
// R10 - Recovery resets only watchdog and oscillator control
// R11 - Recovery selects internal precision oscillator
// R12 - Fetch vector at 0002H/0003H on exit
// R13 - Recovery sets stop-recovery flag
// R14 - Pin or debug low in stop: reset
// R15 - Watchdog in stop: recovery, both flags
// R16 - Watchdog interrupt serviced after watchdog recovery
// R17 - Filtered GPIO transition starts recovery
// R18 - Port input data disabled in stop
// R19 - Reset pin glitch filtered in stop
// R20 - Low-supply flag live, never cleared
// R21 - Low-supply interrupt when enabled
// R22 - Brownout disable also disables low-supply
// R23 - System reset holds 66 or 5000 cycles
// R24 - Status read clears upper four flags
// R25 - Two-stage sync on pin and GPIO inputs
module rsr_ctrl
   import rsr_pkg::*;
#(
   parameter int GPIO_W    = 8,
   parameter int DLY_LONG  = `RSR_DLY_LONG,
   parameter int STOP_FILT = `RSR_STOP_FILT_CYC
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Open-drain reset pin
   input  wire logic              rst_pin_in,
   output logic                   rst_pin_out,
   output logic                   rst_pin_oe_n,
   // Asynchronous sources
   input  wire logic              debug_pin_in,
   input  wire logic              low_supply_in,
   input  wire logic              brownout_in,
   input  wire logic [GPIO_W-1:0] gpio_in,
   // Same-domain sources and option bits
   input  wire logic              wdt_timeout,
   input  wire logic              watchdog_reset_select,
   input  wire logic              xtal_enable,
   input  wire logic              gpio_rst_drive,
   input  wire logic              stop_req,
   // Reset and recovery outputs
   output logic                   sys_rst_n,
   output logic                   cpu_rst_n,
   output logic                   ctl_regs_rst,
   output logic                   osc_force_ipo,
   output logic                   port_in_enable,
   output logic                   stop_mode,
   output logic                   vector_fetch,
   output logic      [15:0]       vector_addr,
   output logic                   wdt_irq,
   output logic                   lvd_irq
);
   localparam int CW = `RSR_CNT_W;

   rsr_wake_if #(.GPIO_W(GPIO_W)) wk ();  // Filter carrier

   rsr_state_e        st_reg;           // Sequencer state
   rsr_state_e        st_next;          // Next sequencer state
   logic [CW-1:0]     cnt_reg;          // Delay down-counter
   logic [3:0]        flags_reg;        // {por, stop, wdt, ext}
   logic              dbg_req_reg;      // Debugger reset request
   logic              lvd_ie_reg;       // Low-supply interrupt enable
   logic              bod_dis_reg;      // Brownout detect disable
   logic [GPIO_W-1:0] wake_en_reg;      // GPIO recovery enables
   logic              smr_wdt_reg;      // Recovery caused by watchdog
   logic              vec_reg;          // Vector fetch pulse
   logic              irq_reg;          // Watchdog interrupt pulse
   logic [31:0]       prdata_reg;       // Read data
   logic              go_rst;           // Enter system reset
   logic              go_smr;           // Enter stop recovery
   rsr_cause_t        cause;            // Cause flags to record
   logic              bo_act;           // Brownout reset active
   logic              lvd_flag;         // Live low-supply flag
   logic              acc;              // APB access phase
   logic              setup_rd;         // APB read setup phase
   logic              rd_status;        // Status read completes
   logic              wdt_int_now;      // Timeout as interrupt

   // Delay for system reset or recovery, in cycles minus one
   function automatic logic [CW-1:0] dly(input logic xtal,
                                         input logic stop_recovery);
      int d;
      d = xtal ? DLY_LONG : `RSR_DLY_SHORT;
      if (stop_recovery && !xtal)
         d = d + `RSR_IPO_START_CYC;
      dly = CW'(d - 1);
   endfunction

   // Is the address one of ours
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `RSR_ADDR_STATUS) || (a == `RSR_ADDR_CTRL) ||
               (a == `RSR_ADDR_WAKE);
   endfunction

   // Pin filtering and synchronisers
   rsr_wake_filter #(
      .GPIO_W    (GPIO_W),
      .STOP_FILT (STOP_FILT)
   ) u_filt (
      .clk_sys       (clk_sys),
      .arst_n        (arst_n),
      .rst_pin_in    (rst_pin_in),
      .debug_pin_in  (debug_pin_in),
      .low_supply_in (low_supply_in),
      .brownout_in   (brownout_in),
      .gpio_in       (gpio_in),
      .wk            (wk.filt)
   );

   // Own drive of the reset pin must not look like an external reset
   assign wk.ignore_pin = !rst_pin_oe_n;
   assign wk.stop       = (st_reg == RSR_STOP);
   assign wk.wake_en    = wake_en_reg;

   assign bo_act   = wk.bo_s && !bod_dis_reg;
   assign lvd_flag = wk.lvd_s && !bod_dis_reg; // R20 R22
   assign wdt_int_now = wdt_timeout && !watchdog_reset_select &&
                        (st_reg == RSR_RUN); // R01

   // Next state and cause selection
   always_comb begin
      st_next = st_reg;
      go_rst  = 1'b0;
      go_smr  = 1'b0;
      cause   = `RSR_CAUSE_POR;
      unique case (st_reg)
         RSR_BOOT: begin
            go_rst = 1'b1;  // Power-on entry
         end
         RSR_RUN: begin
            if (bo_act) begin
               go_rst = 1'b1;
            end else if (dbg_req_reg) begin
               go_rst = 1'b1; // R07
            end else if (wk.pin_low_run) begin
               go_rst = 1'b1; // R03
               cause  = `RSR_CAUSE_EXT; // R05
            end else if (wdt_timeout && watchdog_reset_select) begin
               go_rst = 1'b1; // R01
               cause  = `RSR_CAUSE_WDT; // R02
            end else if (stop_req) begin
               st_next = RSR_STOP;
            end
         end
         RSR_STOP: begin
            if (bo_act) begin
               go_rst = 1'b1;
            end else if (wk.pin_low_stop) begin
               go_rst = 1'b1; // R14 R19
               cause  = `RSR_CAUSE_EXT;
            end else if (wk.dbg_low) begin
               go_rst = 1'b1; // R14
            end else if (wdt_timeout) begin
               go_smr = 1'b1; // R15
               cause  = `RSR_CAUSE_SMR_WDT; // R15
            end else if (wk.gpio_wake) begin
               go_smr = 1'b1; // R17
               cause  = `RSR_CAUSE_SMR; // R13
            end
         end
         RSR_SYSRST: begin
            if (cnt_reg == '0 && !bo_act)
               st_next = RSR_HOLD; // R23
         end
         RSR_HOLD: begin
            if (wk.pin_high)
               st_next = RSR_RUN; // R04
         end
         RSR_SMR: begin
            if (cnt_reg == '0)
               st_next = RSR_RUN; // R09
         end
      endcase
      if (go_rst)
         st_next = RSR_SYSRST;
      if (go_smr)
         st_next = RSR_SMR;
   end

   // State register, power-on enters boot
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         st_reg <= RSR_BOOT;
      else
         st_reg <= st_next;
   end

   // Delay counter, restarts while brownout persists
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         cnt_reg <= '0;
      else if (go_rst || (st_reg == RSR_SYSRST && bo_act))
         cnt_reg <= dly(xtal_enable, 1'b0); // R23
      else if (go_smr)
         cnt_reg <= dly(xtal_enable, 1'b1); // R09
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end

   // Remember a watchdog-caused recovery for its interrupt
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         smr_wdt_reg <= 1'b0;
      else if (go_smr)
         smr_wdt_reg <= wdt_timeout;
      else if (go_rst)
         smr_wdt_reg <= 1'b0;
   end

   // Vector fetch pulse on leaving reset or recovery, interrupt pulse on run timeout or on leaving watchdog recovery
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vec_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         vec_reg <= (st_reg != RSR_RUN) &&
                    (st_next == RSR_RUN); // R12
         irq_reg <= wdt_int_now ||
                    (st_reg == RSR_SMR && st_next == RSR_RUN &&
                     smr_wdt_reg && !watchdog_reset_select); // R16
      end
   end

   // APB phases
   assign acc       = psel && penable;
   assign setup_rd  = psel && !penable && !pwrite;
   assign rd_status = acc && !pwrite && (paddr == `RSR_ADDR_STATUS);

   // Cause flags, a new cause wins over a read clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         flags_reg <= `RSR_ST_RESET;
      else if (go_rst || go_smr)
         flags_reg <= cause; // R02 R05 R08 R13 R15
      else if (rd_status)
         flags_reg <= 4'h0; // R24
   end

   // Debugger request, cleared by the reset it causes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         dbg_req_reg <= 1'b0;
      else if (acc && pwrite && paddr == `RSR_ADDR_CTRL &&
               pwdata[`RSR_CT_DBG_RST])
         dbg_req_reg <= 1'b1;
      else if (st_reg == RSR_SYSRST)
         dbg_req_reg <= 1'b0; // R08
   end

   // Control bits, survive recovery, reset by system reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lvd_ie_reg  <= 1'b0;
         bod_dis_reg <= 1'b0;
         wake_en_reg <= '0;
      end else if (st_reg == RSR_SYSRST) begin
         lvd_ie_reg  <= 1'b0;
         bod_dis_reg <= 1'b0;
         wake_en_reg <= '0;
      end else if (acc && pwrite) begin
         if (paddr == `RSR_ADDR_CTRL) begin
            lvd_ie_reg  <= pwdata[`RSR_CT_LVD_IE];
            bod_dis_reg <= pwdata[`RSR_CT_BOD_DIS]; // R22
         end
         if (paddr == `RSR_ADDR_WAKE)
            wake_en_reg <= pwdata[GPIO_W-1:0];
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_reg <= 32'h0000_0000;
         if (paddr == `RSR_ADDR_STATUS) begin
            prdata_reg[`RSR_ST_POR:`RSR_ST_EXT] <= flags_reg;
            prdata_reg[`RSR_ST_LVD] <= lvd_flag; // R20
         end else if (paddr == `RSR_ADDR_CTRL) begin
            prdata_reg[`RSR_CT_DBG_RST] <= dbg_req_reg;
            prdata_reg[`RSR_CT_LVD_IE]  <= lvd_ie_reg;
            prdata_reg[`RSR_CT_BOD_DIS] <= bod_dis_reg;
         end else if (paddr == `RSR_ADDR_WAKE) begin
            prdata_reg[GPIO_W-1:0] <= wake_en_reg;
         end
      end
   end

   // Bus answers: no wait states, error on unmapped access
   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped(paddr);

   // Reset pin: open drain, low during reset or on GPIO request
   assign rst_pin_out  = 1'b0;
   assign rst_pin_oe_n = !(st_reg == RSR_SYSRST ||
                           st_reg == RSR_BOOT || gpio_rst_drive); // R06

   // System and core resets; the debug unit sees only arst_n
   assign sys_rst_n = !(st_reg == RSR_SYSRST || st_reg == RSR_HOLD ||
                        st_reg == RSR_BOOT); // R04 R07
   assign cpu_rst_n = sys_rst_n && (st_reg != RSR_SMR); // R09
   assign ctl_regs_rst   = (st_reg == RSR_SMR); // R10
   assign osc_force_ipo  = !cpu_rst_n; // R11
   assign port_in_enable = (st_reg == RSR_RUN); // R18
   assign stop_mode      = (st_reg == RSR_STOP);
   assign vector_fetch   = vec_reg; // R12
   assign vector_addr    = `RSR_VEC_ADDR;
   assign wdt_irq        = irq_reg; // R01 R16
   assign lvd_irq        = lvd_flag && lvd_ie_reg; // R21
endmodule
`default_nettype wire

// *** rsr_defs.svh ***
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH
// Register byte addresses
`define RSR_ADDR_STATUS   12'hFF0
`define RSR_ADDR_CTRL     12'hFF4
`define RSR_ADDR_WAKE     12'hFF8
// Status fields
`define RSR_ST_POR        7
`define RSR_ST_STOP       6
`define RSR_ST_WDT        5
`define RSR_ST_EXT        4
`define RSR_ST_LVD        0
`define RSR_ST_RESET      4'h8
// Cause codes {por, stop, wdt, ext}
`define RSR_CAUSE_POR     4'h8
`define RSR_CAUSE_EXT     4'h1
`define RSR_CAUSE_WDT     4'h2
`define RSR_CAUSE_SMR     4'h4
`define RSR_CAUSE_SMR_WDT 4'h6
// Control fields
`define RSR_CT_DBG_RST    0
`define RSR_CT_LVD_IE     1
`define RSR_CT_BOD_DIS    2
// Reset vector location
`define RSR_VEC_ADDR      16'h0002
// Timing, clock period and delays
`define RSR_CLK_PS        5000
`define RSR_DLY_SHORT     66
`define RSR_DLY_LONG      5000
`define RSR_IPO_START_NS  4000
`define RSR_IPO_START_CYC ((`RSR_IPO_START_NS * 1000) / `RSR_CLK_PS)
`define RSR_PIN_MIN_CYC   3
`define RSR_STOP_FILT_NS  50
`define RSR_STOP_FILT_CYC \
   ((`RSR_STOP_FILT_NS * 1000 + `RSR_CLK_PS - 1) / `RSR_CLK_PS)
`define RSR_CNT_W         13
`endif

// *** rsr_pkg.sv ***
// Types shared by the sequencer files
package rsr_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      RSR_BOOT, RSR_SYSRST, RSR_HOLD, RSR_RUN, RSR_STOP, RSR_SMR
   } rsr_state_e;
   // Cause field {por, stop, wdt, ext}
   typedef logic [3:0] rsr_cause_t;
endpackage

// *** rsr_wake_if.sv ***
// Carrier between the sequencer and its pin filter
`timescale 1ns/1ps
`default_nettype none
interface rsr_wake_if #(parameter int GPIO_W = 8);
   logic              ignore_pin;   // Pin driven by us, do not count
   logic              stop;         // Stop mode active
   logic [GPIO_W-1:0] wake_en;      // GPIO recovery enables
   logic              pin_low_run;  // Reset pin low long enough, run
   logic              pin_low_stop; // Reset pin low past stop filter
   logic              pin_high;     // Synchronised reset pin level
   logic              dbg_low;      // Debug pin held low
   logic              gpio_wake;    // Filtered GPIO transition
   logic              lvd_s;        // Synchronised low-supply level
   logic              bo_s;         // Synchronised brownout level
   modport filt (input ignore_pin, stop, wake_en,
      output pin_low_run, pin_low_stop, pin_high, dbg_low,
      gpio_wake, lvd_s, bo_s);
   modport ctrl (output ignore_pin, stop, wake_en,
      input pin_low_run, pin_low_stop, pin_high, dbg_low,
      gpio_wake, lvd_s, bo_s);
endinterface
`default_nettype wire

// *** rsr_wake_filter.sv ***
// Pin synchronisers, reset pin width filter and GPIO wake detector
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
module rsr_wake_filter
   import rsr_pkg::*;
#(
   parameter int       GPIO_W    = 8,
   parameter int       STOP_FILT = `RSR_STOP_FILT_CYC
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   // Raw asynchronous inputs
   input  wire logic              rst_pin_in,
   input  wire logic              debug_pin_in,
   input  wire logic              low_supply_in,
   input  wire logic              brownout_in,
   input  wire logic [GPIO_W-1:0] gpio_in,
   // Towards the sequencer
   rsr_wake_if.filt               wk
);
   localparam int SW = GPIO_W + 4;
   localparam logic [7:0] PMIN = 8'(`RSR_PIN_MIN_CYC);
   localparam logic [7:0] SFLT = 8'(STOP_FILT);
   logic [SW-1:0]     s1_reg;      // First stage, read by s2 only
   logic [SW-1:0]     s2_reg;      // Second stage, safe to use
   logic [7:0]        pcnt_reg;    // Reset pin low width
   logic [7:0]        gcnt_reg;    // GPIO mismatch width
   logic [GPIO_W-1:0] gref_reg;    // GPIO level at stop entry
   logic              mism;        // Enabled GPIO differs from entry

   // Saturating count up
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hFF) ? v : v + 8'h01;
   endfunction

   // Two-flop synchroniser, reset and debug pins idle high
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= {2'b11, 2'b00, {GPIO_W{1'b0}}};
         s2_reg <= {2'b11, 2'b00, {GPIO_W{1'b0}}};
      end else begin
         s1_reg <= {rst_pin_in, debug_pin_in, low_supply_in,
                    brownout_in, gpio_in}; // R25
         s2_reg <= s1_reg; // R25
      end
   end

   // Consecutive low cycles of the reset pin
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         pcnt_reg <= 8'h00;
      else if (s2_reg[SW-1] || wk.ignore_pin)
         pcnt_reg <= 8'h00;
      else
         pcnt_reg <= sat_inc(pcnt_reg); // R03
   end

   // GPIO reference follows pins outside stop mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         gref_reg <= '0;
      else if (!wk.stop)
         gref_reg <= s2_reg[GPIO_W-1:0];
   end

   assign mism = |((s2_reg[GPIO_W-1:0] ^ gref_reg) & wk.wake_en); // R17

   // Width of a GPIO transition in stop mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         gcnt_reg <= 8'h00;
      else if (!mism || !wk.stop)
         gcnt_reg <= 8'h00;
      else
         gcnt_reg <= sat_inc(gcnt_reg); // R17
   end

   assign wk.pin_low_run  = pcnt_reg >= PMIN; // R03
   assign wk.pin_low_stop = pcnt_reg >= SFLT; // R19
   assign wk.pin_high     = s2_reg[SW-1];
   assign wk.dbg_low      = !s2_reg[SW-2];
   assign wk.lvd_s        = s2_reg[GPIO_W+1];
   assign wk.bo_s         = s2_reg[GPIO_W];
   assign wk.gpio_wake    = gcnt_reg >= SFLT; // R17
endmodule
`default_nettype wire

// *** rsr_ctrl_sva.sv ***
// Checker on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
module rsr_ctrl_sva
   import rsr_pkg::*;
#(
   parameter int DLY_LONG = `RSR_DLY_LONG
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Watchdog and option inputs
   input wire logic wdt_timeout,
   input wire logic watchdog_reset_select,
   input wire logic xtal_enable,
   input wire logic gpio_rst_drive,
   // Sequencer outputs
   input wire logic rst_pin_oe_n,
   input wire logic sys_rst_n,
   input wire logic cpu_rst_n,
   input wire logic ctl_regs_rst,
   input wire logic osc_force_ipo,
   input wire logic port_in_enable,
   input wire logic stop_mode,
   input wire logic vector_fetch,
   input wire logic wdt_irq
);
   localparam int SMR_SHORT = `RSR_DLY_SHORT + `RSR_IPO_START_CYC;
   logic [15:0] pin_cnt; // Cycles the pin has been driven
   logic [15:0] smr_cnt; // Cycles of control reset
   logic        armed;   // Run has been reached once
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Run lengths of pin drive and of recovery
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_cnt <= 16'h0000;
         smr_cnt <= 16'h0000;
      end else begin
         pin_cnt <= rst_pin_oe_n ? 16'h0000 : pin_cnt + 16'h0001;
         smr_cnt <= ctl_regs_rst ? smr_cnt + 16'h0001 : 16'h0000;
      end
   end
   // First reset after power-on has a boot cycle, so skip it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) armed <= 1'b0;
      else if (sys_rst_n) armed <= 1'b1;
   end
   a_wdt_run_reset: assert property (port_in_enable && wdt_timeout &&
      watchdog_reset_select |=> !sys_rst_n && !cpu_rst_n)
      else $error("Watchdog timeout gave no reset");
   a_wdt_run_irq: assert property (port_in_enable && wdt_timeout &&
      !watchdog_reset_select |=> wdt_irq && sys_rst_n)
      else $error("Watchdog timeout gave no interrupt");
   a_smr_entry: assert property (stop_mode && wdt_timeout
      |=> ctl_regs_rst && !cpu_rst_n && sys_rst_n)
      else $error("Watchdog in stop gave no recovery");
   a_smr_length: assert property ($fell(ctl_regs_rst) |->
      int'(smr_cnt) == (xtal_enable ? DLY_LONG : SMR_SHORT))
      else $error("Recovery length wrong");
   a_sysrst_length: assert property ($rose(rst_pin_oe_n) && armed &&
      !sys_rst_n |-> int'(pin_cnt) == (xtal_enable ? DLY_LONG : 66))
      else $error("Reset pin drive length wrong");
   a_gpio_drive: assert property (gpio_rst_drive &&
      $past(gpio_rst_drive) |-> !rst_pin_oe_n)
      else $error("Pin not driven for port logic");
   a_ipo_forced: assert property (!cpu_rst_n |-> osc_force_ipo)
      else $error("Oscillator not forced in reset");
   a_vector_run: assert property ($rose(port_in_enable) |->
      ##[0:1] vector_fetch)
      else $error("No vector fetch on leaving reset");
   a_port_in_stop: assert property (stop_mode |-> !port_in_enable)
      else $error("Port input active in stop");
endmodule
bind rsr_ctrl rsr_ctrl_sva #(.DLY_LONG(DLY_LONG)) u_sva (.*);
`default_nettype wire

// *** rsr_pin_model.sv ***
// Other party on the open-drain reset line, line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module rsr_pin_model (
   // Clock
   input  wire logic        clk_sys,
   // Device driver of the line
   input  wire logic        rst_pin_out,
   input  wire logic        rst_pin_oe_n,
   // Request for a low pulse
   input  wire logic        pull_go,
   input  wire logic [15:0] pull_len,
   // Resolved line level
   output logic             pin
);
   logic [15:0] left = 16'h0000; // Cycles still held low
   // Holds the line low for the asked number of cycles
   always_ff @(posedge clk_sys) begin
      if (pull_go) left <= pull_len;
      else if (left != 16'h0000) left <= left - 16'h0001;
   end
   // Wired-AND of both drivers, pull-up when nobody drives
   assign pin = ((!rst_pin_oe_n && !rst_pin_out) || left != 16'h0000)
      ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** test_reset_stop_recovery_ctrl.sv ***
// Self-checking bench of the reset and stop-recovery sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
`define RSR_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) \
   begin failures++; $display("Error at %0t: got %h expected %h", \
   $time, got, exp); end end
module test_reset_stop_recovery_ctrl
   import rsr_pkg::*;
;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic e;}
      rsr_tb_row_s;
   logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata_q;
   logic        rst_pin_in, rst_pin_out, rst_pin_oe_n, debug_pin_in;
   logic        low_supply_in, wdt_timeout, watchdog_reset_select;
   logic        brownout_in, xtal_enable, gpio_rst_drive, stop_req;
   logic [7:0]  gpio_in;
   logic        sys_rst_n, cpu_rst_n, ctl_regs_rst, osc_force_ipo;
   logic        port_in_enable, stop_mode, vector_fetch, wdt_irq;
   logic        lvd_irq, err_q, pull_go;
   logic [15:0] vector_addr, pull_len;
   int          failures, num_checks, cycles;
   // Register cases: write, address, data, read value, error
   rsr_tb_row_s rows [10] = '{
      '{0, `RSR_ADDR_STATUS, 0, 32'h80, 0}, '{0, `RSR_ADDR_STATUS, 0, 0, 0},
      '{1, `RSR_ADDR_STATUS, 32'hFF, 0, 0}, '{0, `RSR_ADDR_STATUS, 0, 0, 0},
      '{1, `RSR_ADDR_CTRL, 32'h2, 0, 0}, '{0, `RSR_ADDR_CTRL, 0, 32'h2, 0},
      '{1, `RSR_ADDR_WAKE, 32'h1, 0, 0}, '{0, `RSR_ADDR_WAKE, 0, 32'h1, 0},
      '{0, 12'hFFC, 0, 0, 1}, '{1, 12'h000, 0, 0, 1}};
   rsr_ctrl #(.DLY_LONG(20)) u_dut (.*);
   rsr_pin_model u_pin (.clk_sys(clk_sys), .rst_pin_out(rst_pin_out),
      .rst_pin_oe_n(rst_pin_oe_n), .pull_go(pull_go),
      .pull_len(pull_len), .pin(rst_pin_in));
   // Clock of 5 ns
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task automatic finish_test();
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdata_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `RSR_CHK(rdata_q, x)
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wait_vf();
      do @(negedge clk_sys); while (vector_fetch !== 1'b1);
   endtask
   task automatic pulse_wdt();
      @(posedge clk_sys);
      wdt_timeout <= 1'b1;
      @(posedge clk_sys);
      wdt_timeout <= 1'b0;
   endtask
   task automatic pin_low(input logic [15:0] n);
      @(posedge clk_sys);
      pull_go <= 1'b1;
      pull_len <= n;
      @(posedge clk_sys);
      pull_go <= 1'b0;
   endtask
   task automatic enter_stop();
      @(posedge clk_sys);
      stop_req <= 1'b1;
      @(posedge clk_sys);
      stop_req <= 1'b0;
      do @(negedge clk_sys); while (stop_mode !== 1'b1);
      @(posedge clk_sys);
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pull_go, pull_len} = '0;
      {low_supply_in, wdt_timeout, brownout_in, xtal_enable} = '0;
      {gpio_rst_drive, stop_req, gpio_in, failures, num_checks} = '0;
      {cycles, debug_pin_in, watchdog_reset_select, arst_n} = 35'h6;
      tick(12);
      arst_n <= 1'b1;
      wait_vf();
      `RSR_CHK(vector_addr, `RSR_VEC_ADDR)
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         `RSR_CHK(err_q, rows[i].e)
         if (!rows[i].w) `RSR_CHK(rdata_q, rows[i].x)
      end
      low_supply_in <= 1'b1;
      tick(4);
      `RSR_CHK(lvd_irq, 1'b1)
      rd(`RSR_ADDR_STATUS, 32'h1);
      rd(`RSR_ADDR_STATUS, 32'h1);
      apb(1'b1, `RSR_ADDR_CTRL, 32'h6);
      rd(`RSR_ADDR_STATUS, 32'h0);
      `RSR_CHK(lvd_irq, 1'b0)
      low_supply_in <= 1'b0;
      apb(1'b1, `RSR_ADDR_CTRL, 32'h0);
      watchdog_reset_select <= 1'b0;
      pulse_wdt();
      @(negedge clk_sys);
      `RSR_CHK(wdt_irq, 1'b1)
      tick(1);
      watchdog_reset_select <= 1'b1;
      pulse_wdt();
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h20);
      pin_low(16'd2);
      tick(20);
      `RSR_CHK(sys_rst_n, 1'b1)
      pin_low(16'd4);
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h10);
      pin_low(16'd200);
      tick(150);
      `RSR_CHK(sys_rst_n, 1'b0)
      wait_vf();
      tick(1);
      xtal_enable <= 1'b1;
      apb(1'b1, `RSR_ADDR_CTRL, 32'h1);
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h80);
      rd(`RSR_ADDR_CTRL, 32'h0);
      xtal_enable <= 1'b0;
      gpio_rst_drive <= 1'b1;
      tick(3);
      `RSR_CHK(rst_pin_oe_n, 1'b0)
      gpio_rst_drive <= 1'b0;
      tick(20);
      `RSR_CHK(sys_rst_n, 1'b1)
      watchdog_reset_select <= 1'b0;
      apb(1'b1, `RSR_ADDR_WAKE, 32'h1);
      enter_stop();
      pulse_wdt();
      @(negedge clk_sys);
      `RSR_CHK(ctl_regs_rst, 1'b1)
      wait_vf();
      `RSR_CHK(wdt_irq, 1'b1)
      rd(`RSR_ADDR_STATUS, 32'h60);
      rd(`RSR_ADDR_WAKE, 32'h1);
      enter_stop();
      gpio_in <= 8'h01;
      tick(3);
      gpio_in <= 8'h02;
      tick(30);
      `RSR_CHK(stop_mode, 1'b1)
      gpio_in <= 8'h03;
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h40);
      enter_stop();
      pin_low(16'd5);
      tick(20);
      `RSR_CHK(stop_mode, 1'b1)
      pin_low(16'd20);
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h10);
      enter_stop();
      debug_pin_in <= 1'b0;
      tick(20);
      debug_pin_in <= 1'b1;
      wait_vf();
      rd(`RSR_ADDR_STATUS, 32'h80);
      finish_test();
   end
endmodule
`default_nettype wire
